// file: hw/fpes_defines.vh
/*
 Constants for the flash program/erase host sequencer: command codes,
 status bit positions, register offsets and bus cycle timing.
 Assumes inclusion by the sequencer module and by the test bench.
*/
`ifndef FPES_DEFINES_VH
`define FPES_DEFINES_VH

// Flash command codes
`define FPES_CMD_PROGRAM 8'h40
`define FPES_CMD_ERASE 8'h20
`define FPES_CMD_CONFIRM 8'hD0
`define FPES_CMD_SUSPEND 8'hB0
`define FPES_CMD_STATUS 8'h70
`define FPES_CMD_CLEAR 8'h50
`define FPES_CMD_READ 8'hFF

// Status bit positions
`define FPES_SR_READY 7
`define FPES_SR_ERS_SUSP 6
`define FPES_SR_ERS_ERR 5
`define FPES_SR_PRG_ERR 4
`define FPES_SR_SUPPLY_ERR 3
`define FPES_SR_PRG_SUSP 2
`define FPES_SR_LOCKED 1

// Host operation codes in the control register
`define FPES_OP_READ 3'h0
`define FPES_OP_PROGRAM 3'h1
`define FPES_OP_ERASE 3'h2
`define FPES_OP_SUSPEND 3'h3
`define FPES_OP_RESUME 3'h4
`define FPES_OP_CLEAR 3'h5
`define FPES_OP_STATUS 3'h6

// Wishbone register byte offsets
`define FPES_REG_CTRL 4'h0
`define FPES_REG_ADDR 4'h4
`define FPES_REG_DATA 4'h8
`define FPES_REG_STAT 4'hC

// Strobe timing: 70 ns access, rounded up at 10 ns
`define FPES_CLK_NS 10
`define FPES_STROBE_NS 70
`define FPES_STROBE_CYC ((`FPES_STROBE_NS + `FPES_CLK_NS - 1) / `FPES_CLK_NS)
// Suspend latencies in microseconds
`define FPES_PRG_SUSP_US 10
`define FPES_ERS_SUSP_US 15
`define FPES_PRG_SUSP_CYC (`FPES_PRG_SUSP_US * 1000 / `FPES_CLK_NS)
`define FPES_ERS_SUSP_CYC (`FPES_ERS_SUSP_US * 1000 / `FPES_CLK_NS)

`endif

// file: hw/fpes_host_sequencer.v
/*
 Host controller that drives a clockless parallel NOR flash through its
 chip-select, output-enable and write-enable strobes, issuing program,
 erase, suspend, resume, clear and read-status sequences ordered by
 software over a classic Wishbone slave. Assumes the flash pins are
 wired directly; data pins are tristated by the bench from flash_dq_oe_o.
*/
// The implementer's own choices: the Wishbone slave port and the address map.
// Overview of operation
// - Program: write 40 anywhere, then the data word at target.
// - Each status read toggles chip-select and output-enable afresh.
// - Write FF after the last operation to return to array read.
// - Program suspend: B0 then 70; bit 2 shows suspended state.
// - While program suspended, FF gives array reads; D0 resumes.
// - Erase: write 20 anywhere, then D0 within the sector.
// - Erase suspended: FF reads or 40 programs elsewhere; D0 resumes.
`timescale 1ns/1ps
`default_nettype none
`include "fpes_defines.vh"

module fpes_host_sequencer (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Flash pins
    output reg flash_ce_n_o,
    output reg flash_oe_n_o,
    output reg flash_we_n_o,
    output reg [19:0] flash_addr_o,
    output reg [15:0] flash_dq_o,
    output reg flash_dq_oe_o,
    input wire [15:0] flash_dq_i
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_WRITE = 3'h1;
    localparam [2:0] ST_READ = 3'h2;
    localparam [2:0] ST_GAP = 3'h3;
    localparam [2:0] ST_POLL = 3'h4;
    localparam integer STROBE_INT = `FPES_STROBE_CYC;
    localparam [3:0] STROBE_CYC = STROBE_INT[3:0];

    // Software visible state, and the internal preempt flag
    reg [2:0] op;
    reg op_busy;
    reg [19:0] target_addr;
    reg [15:0] write_word;
    reg [7:0] last_status;
    reg [15:0] last_array;
    reg refused;
    reg status_mode;
    reg preempt;
    // Sequencer state
    reg [2:0] state;
    reg [1:0] step;
    reg [3:0] cnt;
    reg poll_done;
    reg [7:0] seq_code [0:1];
    reg seq_has_data;
    reg [1:0] seq_len;
    reg seq_poll;
    // Data pins pass three flops, two must agree
    reg [15:0] dq_s1;
    reg [15:0] dq_s2;
    reg [15:0] dq_s3;
    reg [15:0] dq_stable;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [15:0] dq_sample = dq_stable;
    // Suspend may cut into the polling of a running program or erase
    wire can_suspend = op_busy && step == 2'h3 &&
        (op == `FPES_OP_PROGRAM || op == `FPES_OP_ERASE) &&
        wb_dat_i[2:0] == `FPES_OP_SUSPEND;

    function err_blocks;
        input [2:0] kind;
        input [7:0] sr;
        begin
            if (kind == `FPES_OP_PROGRAM)
                err_blocks = sr[`FPES_SR_SUPPLY_ERR];
            else if (kind == `FPES_OP_ERASE)
                err_blocks = sr[`FPES_SR_SUPPLY_ERR] | sr[`FPES_SR_LOCKED]
                    | sr[`FPES_SR_ERS_SUSP];
            else
                err_blocks = 1'b0;
        end
    endfunction

    always @(posedge clk_i) begin
        dq_s1 <= flash_dq_i;
        dq_s2 <= dq_s1;
        dq_s3 <= dq_s2;
        if (dq_s2 == dq_s3)
            dq_stable <= dq_s3;
    end

    // Wishbone register file, one cycle answer
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            op <= `FPES_OP_READ;
            op_busy <= 1'b0;
            target_addr <= 20'h00000;
            write_word <= 16'h0000;
            refused <= 1'b0;
            preempt <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            if (state == ST_IDLE && op_busy && poll_done && !preempt)
                op_busy <= 1'b0;
            // Sequencer has restarted by now; a set below still wins
            if (state == ST_IDLE)
                preempt <= 1'b0;
            if (wb_req && wb_we_i) begin
                case (wb_adr_i)
                `FPES_REG_CTRL: begin
                    if (wb_sel_i[0] && (!op_busy || can_suspend)) begin
                        if (err_blocks(wb_dat_i[2:0], last_status)) begin
                            refused <= 1'b1;
                        end else begin
                            refused <= 1'b0;
                            op <= wb_dat_i[2:0];
                            op_busy <= 1'b1;
                            preempt <= op_busy;
                        end
                    end
                end
                `FPES_REG_ADDR: begin
                    if (wb_sel_i[0])
                        target_addr[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        target_addr[15:8] <= wb_dat_i[15:8];
                    if (wb_sel_i[2])
                        target_addr[19:16] <= wb_dat_i[19:16];
                end
                `FPES_REG_DATA: begin
                    if (wb_sel_i[0])
                        write_word[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        write_word[15:8] <= wb_dat_i[15:8];
                end
                default: ;
                endcase
            end
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                `FPES_REG_CTRL:
                    wb_dat_o <= {26'h0000000, status_mode, refused,
                        op_busy, op};
                `FPES_REG_ADDR: wb_dat_o <= {12'h000, target_addr};
                `FPES_REG_DATA: wb_dat_o <= {16'h0000, last_array};
                `FPES_REG_STAT: wb_dat_o <= {24'h000000, last_status};
                default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Sequence decode: codes, data phase, and whether to poll ready
    always @* begin
        seq_code[0] = `FPES_CMD_READ;
        seq_code[1] = `FPES_CMD_READ;
        seq_has_data = 1'b0;
        seq_len = 2'h1;
        seq_poll = 1'b0;
        case (op)
        `FPES_OP_PROGRAM: begin
            seq_code[0] = `FPES_CMD_PROGRAM;
            seq_has_data = 1'b1;
            seq_poll = 1'b1;
        end
        `FPES_OP_ERASE: begin
            seq_code[0] = `FPES_CMD_ERASE;
            seq_code[1] = `FPES_CMD_CONFIRM;
            seq_len = 2'h2;
            seq_poll = 1'b1;
        end
        `FPES_OP_SUSPEND: begin
            seq_code[0] = `FPES_CMD_SUSPEND;
            seq_code[1] = `FPES_CMD_STATUS;
            seq_len = 2'h2;
            seq_poll = 1'b1;
        end
        `FPES_OP_RESUME: seq_code[0] = `FPES_CMD_CONFIRM;
        `FPES_OP_CLEAR: seq_code[0] = `FPES_CMD_CLEAR;
        `FPES_OP_STATUS: seq_code[0] = `FPES_CMD_STATUS;
        default: seq_code[0] = `FPES_CMD_READ;
        endcase
    end

    // Flash strobe sequencer
    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            step <= 2'h0;
            cnt <= 4'h0;
            poll_done <= 1'b0;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_addr_o <= 20'h00000;
            flash_dq_o <= 16'h0000;
            flash_dq_oe_o <= 1'b0;
            last_status <= 8'h80;
            last_array <= 16'h0000;
            status_mode <= 1'b0;
        end else begin
            case (state)
            ST_IDLE: begin
                if (op_busy && !poll_done) begin
                    flash_ce_n_o <= 1'b0;
                    flash_dq_oe_o <= 1'b1;
                    flash_addr_o <= (step == 2'h1) ? target_addr : 20'h00000;
                    if (step == 2'h1 && seq_has_data)
                        flash_dq_o <= write_word;
                    else
                        flash_dq_o <= {8'h00, seq_code[step[0]]};
                    flash_we_n_o <= 1'b0;
                    cnt <= STROBE_CYC;
                    state <= ST_WRITE;
                end else if (op_busy && poll_done) begin
                    poll_done <= 1'b0;
                    step <= 2'h0;
                end
            end
            ST_WRITE: begin
                if (cnt != 4'h0) begin
                    cnt <= cnt - 4'h1;
                end else begin
                    flash_we_n_o <= 1'b1;
                    flash_ce_n_o <= 1'b1;
                    flash_dq_oe_o <= 1'b0;
                    cnt <= STROBE_CYC;
                    if (step + 2'h1 < seq_len + {1'b0, seq_has_data}) begin
                        step <= step + 2'h1;
                        state <= ST_GAP;
                    end else begin
                        status_mode <= (op != `FPES_OP_READ) &&
                            (op != `FPES_OP_CLEAR);
                        state <= (op == `FPES_OP_READ) ? ST_GAP : ST_POLL;
                        step <= 2'h3;
                    end
                end
            end
            ST_GAP: begin
                if (cnt != 4'h0) begin
                    cnt <= cnt - 4'h1;
                end else begin
                    state <= ST_IDLE;
                    if (step == 2'h3) begin
                        poll_done <= 1'b1;
                        if (op == `FPES_OP_READ) begin
                            flash_ce_n_o <= 1'b0;
                            flash_oe_n_o <= 1'b0;
                            flash_addr_o <= target_addr;
                            cnt <= STROBE_CYC + STROBE_CYC;
                            state <= ST_READ;
                            poll_done <= 1'b0;
                            step <= 2'h2;
                        end
                    end
                end
            end
            ST_POLL: begin
                if (cnt != 4'h0) begin
                    cnt <= cnt - 4'h1;
                end else if (preempt) begin
                    // Jump only after the gap so writes stay spaced
                    state <= ST_IDLE;
                    step <= 2'h0;
                end else begin
                    flash_ce_n_o <= 1'b0;
                    flash_oe_n_o <= 1'b0;
                    cnt <= STROBE_CYC + STROBE_CYC;
                    state <= ST_READ;
                end
            end
            ST_READ: begin
                if (cnt != 4'h0) begin
                    cnt <= cnt - 4'h1;
                end else begin
                    flash_ce_n_o <= 1'b1;
                    flash_oe_n_o <= 1'b1;
                    cnt <= STROBE_CYC;
                    if (step == 2'h2) begin
                        last_array <= dq_sample;
                        poll_done <= 1'b1;
                        state <= ST_GAP;
                    end else begin
                        last_status <= dq_sample[7:0];
                        // Busy flash: deselect and poll again
                        if (dq_sample[`FPES_SR_READY] || !seq_poll) begin
                            state <= ST_GAP;
                        end else begin
                            state <= ST_POLL;
                        end
                    end
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // fpes_host_sequencer
`default_nettype wire

// file: test/fpes_checker_properties.sv
/* Port checker for the flash sequencer: bus answer and strobe timing.
   Bound onto the sequencer from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module fpes_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Flash
    input wire logic flash_ce_n_o,
    input wire logic flash_oe_n_o,
    input wire logic flash_we_n_o,
    input wire logic [19:0] flash_addr_o,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_dq_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_low;
        (!flash_we_n_o)[*8] ##1 flash_we_n_o;
    endsequence
    sequence s_wr_gap;
        flash_we_n_o[*8];
    endsequence
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
    a_wr_pulse: assert property (
        $fell(flash_we_n_o) |-> s_wr_low ##0 s_wr_gap)
        else $error("write strobe or gap of wrong length");
    a_wr_stable: assert property (
        !flash_we_n_o && !$past(flash_we_n_o) |->
        $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("address or data moved under write strobe");
    a_wr_drive: assert property (
        !flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o)
        else $error("write strobe without select or data drive");
    a_rd_pulse: assert property (
        $fell(flash_oe_n_o) |-> ##14 !flash_oe_n_o ##1 flash_oe_n_o)
        else $error("status read strobe not fifteen cycles");
    a_rd_clean: assert property (
        !flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o && !flash_ce_n_o)
        else $error("read strobe overlaps a drive or write");
endmodule // fpes_checker
`default_nettype wire

// file: test/fpes_flash_model.sv
/* Behavioural clockless flash facing the sequencer.
   A 10 ns tick stands in for the internal write timer. */
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model (
    // Strobes and address
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [19:0] addr_i,
    // Data
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    // Test controls
    input wire logic slow_i,
    input wire logic fault_i
);
    logic [7:0] sr = 8'h80;
    logic [7:0] setup = 8'h00;
    logic [15:0] mem [0:15];
    logic [15:0] last_q = 16'h0000;
    logic [19:0] ers_adr = 20'h00000;
    logic stat_mode = 1'b0, erasing = 1'b0, hold = 1'b0;
    int left = 0;
    task automatic start(input logic e);
        erasing = e;
        left = slow_i ? 4000 : 300;
        sr[7] = 1'b0;
    endtask
    logic armed = 1'b0;
    // Either strobe may move first within the same time step
    always @(negedge we_n_i or negedge ce_n_i)
        if (!we_n_i && !ce_n_i) armed = 1'b1;
    always @(posedge we_n_i or posedge ce_n_i) begin
        if (armed) begin
            armed = 1'b0;
            stat_mode = 1'b1;
            if (setup == 8'h40) begin
                if (fault_i || sr[3]) sr[4:3] = 2'h3;
                else mem[addr_i[3:0]] = dq_i;
                if (!fault_i && !sr[3]) start(1'b0);
            end else if (setup == 8'h20) begin
                ers_adr = addr_i;
                if (dq_i[7:0] != 8'hD0) sr[5:4] = 2'h3;
                else if (!sr[6] && !sr[3] && !sr[1]) start(1'b1);
            end else begin
                case (dq_i[7:0])
                    8'h40, 8'h20: setup = dq_i[7:0];
                    8'hFF: stat_mode = 1'b0;
                    8'h50: sr = sr & 8'hC5;
                    8'hB0: if (!sr[7]) hold = 1'b1;
                    8'hD0: if (hold) begin
                        hold = 1'b0;
                        sr[6] = 1'b0;
                        sr[2] = 1'b0;
                        sr[7] = 1'b0;
                    end
                    8'h70: ;
                    default: sr[5:4] = 2'h3;
                endcase
            end
            if (setup != dq_i[7:0]) setup = 8'h00;
        end
    end
    initial forever begin
        #10;
        if (!sr[7] && hold) begin
            sr[7] = 1'b1;
            sr[erasing ? 6 : 2] = 1'b1;
        end else if (!sr[7] && left == 0) begin
            sr[7] = 1'b1;
            if (erasing) mem = '{default: 16'hFFFF};
        end else if (!sr[7]) left = left - 1;
    end
    // Snapshot per strobe fall or address change so a held strobe shows stale status
    always @(negedge oe_n_i or negedge ce_n_i or addr_i)
        last_q = stat_mode ? {8'h00, sr} : mem[addr_i[3:0]];
    assign dq_o = (!ce_n_i && !oe_n_i) ? last_q : ~last_q;
endmodule // fpes_flash_model
`default_nettype wire

// file: test/flash_program_erase_sequencer_test.sv
/* Self-checking bench: sequencer driven over Wishbone, flash model behind.
   Assumes the design, defines, checker and model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "fpes_defines.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    err_total++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end end
module flash_program_erase_sequencer_test;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0;
    logic wb_we = 1'b0, wb_ack, ce_n, oe_n, we_n, h_oe;
    logic slow = 1'b0, fault = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0, wb_q, rd;
    logic [19:0] f_addr;
    logic [15:0] h_dq, m_dq, dq_in;
    int err_total = 0, num_checks = 0;
    assign dq_in = h_oe ? h_dq : m_dq;
    fpes_host_sequencer fpes_host_sequencer_inst (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .flash_ce_n_o(ce_n),
        .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_addr_o(f_addr),
        .flash_dq_o(h_dq), .flash_dq_oe_o(h_oe), .flash_dq_i(dq_in));
    fpes_flash_model fpes_flash_model_inst (.ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .addr_i(f_addr), .dq_i(h_dq), .dq_o(m_dq),
        .slow_i(slow), .fault_i(fault));
    initial forever #5 clk_i = ~clk_i;
    task automatic wb(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        rd = wb_q;
        `CHK("ack", 1'b1, wb_ack)
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic op(input logic [2:0] k);
        int n;
        n = 0;
        wb(1'b1, `FPES_REG_CTRL, {29'h0, k});
        do begin
            wb(1'b0, `FPES_REG_CTRL, 32'h0);
            n++;
        end while (rd[3] !== 1'b0 && n < 3000);
        `CHK("busy", 1'b0, rd[3])
    endtask
    task automatic t_basic;
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'h80, rd)
        wb(1'b0, 4'h2, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        wb(1'b1, `FPES_REG_ADDR, 32'h5);
        wb(1'b1, `FPES_REG_DATA, 32'h1234);
        op(`FPES_OP_PROGRAM);
        `CHK("word", 16'h1234, fpes_flash_model_inst.mem[5])
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'h80, rd)
        op(`FPES_OP_SUSPEND);
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'h80, rd)
        op(`FPES_OP_READ);
        wb(1'b0, `FPES_REG_DATA, 32'h0);
        `CHK("array", 16'h1234, rd[15:0])
        $display("test basic done");
    endtask
    task automatic t_erase_susp;
        int n;
        n = 0;
        slow = 1'b1;
        wb(1'b1, `FPES_REG_ADDR, 32'h3);
        wb(1'b1, `FPES_REG_CTRL, {29'h0, `FPES_OP_ERASE});
        while (fpes_flash_model_inst.sr[7] !== 1'b0 && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        `CHK("started", 1'b0, fpes_flash_model_inst.sr[7])
        `CHK("sector", 20'h3, fpes_flash_model_inst.ers_adr)
        op(`FPES_OP_SUSPEND);
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'hC0, rd)
        wb(1'b1, `FPES_REG_CTRL, {29'h0, `FPES_OP_ERASE});
        wb(1'b0, `FPES_REG_CTRL, 32'h0);
        `CHK("refused", 1'b1, rd[4])
        op(`FPES_OP_READ);
        `CHK("mode", 1'b0, fpes_flash_model_inst.stat_mode)
        op(`FPES_OP_RESUME);
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'h00, rd)
        // Resume reads status once; poll until the erase finishes
        n = 0;
        do begin
            op(`FPES_OP_STATUS);
            wb(1'b0, `FPES_REG_STAT, 32'h0);
            n++;
        end while (rd[7] !== 1'b1 && n < 300);
        `CHK("status", 32'h80, rd)
        `CHK("erased", 16'hFFFF, fpes_flash_model_inst.mem[5])
        slow = 1'b0;
        $display("test erase suspend done");
    endtask
    task automatic t_fault;
        fault = 1'b1;
        op(`FPES_OP_PROGRAM);
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'h98, rd)
        fault = 1'b0;
        wb(1'b1, `FPES_REG_CTRL, {29'h0, `FPES_OP_PROGRAM});
        wb(1'b0, `FPES_REG_CTRL, 32'h0);
        `CHK("refused", 1'b1, rd[4])
        wb(1'b1, `FPES_REG_CTRL, {29'h0, `FPES_OP_ERASE});
        wb(1'b0, `FPES_REG_CTRL, 32'h0);
        `CHK("refused", 1'b1, rd[4])
        op(`FPES_OP_STATUS);
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'h98, rd)
        op(`FPES_OP_CLEAR);
        op(`FPES_OP_STATUS);
        wb(1'b0, `FPES_REG_STAT, 32'h0);
        `CHK("status", 32'h80, rd)
        $display("test fault done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_basic;
        t_erase_susp;
        t_fault;
        stop_test;
    end
    // Slow erase is the longest wait; a hang past this is a failure
    initial begin
        #1000000;
        err_total++;
        stop_test;
    end
endmodule // flash_program_erase_sequencer_test
bind fpes_host_sequencer fpes_checker fpes_checker_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o));
`default_nettype wire
